/* File: core/dtec_defines.svh */
// Register offsets, field positions, reset values, clock select codes and prescaler width of the dual timer.
`ifndef DTEC_DEFINES_SVH
`define DTEC_DEFINES_SVH
// ==========================================================
// Register offsets.
`define DTEC_OFF_A_CTRL 8'hB2
`define DTEC_OFF_A_DATA 8'hB3
`define DTEC_OFF_B_CTRL 8'hB4
`define DTEC_OFF_B_CMP 8'hB5
`define DTEC_OFF_B_DATA 8'hB6
`define DTEC_OFF_PWM_HI 8'hB7
// ==========================================================
// Reset values.
`define DTEC_RST_CTRL 8'h00
`define DTEC_RST_CMP 8'hFF
`define DTEC_RST_DUTY 8'h00
`define DTEC_RST_HI 8'h00
// ==========================================================
// Control field positions.
`define DTEC_A_EN 7
`define DTEC_A_PE 6
`define DTEC_A_CAP 5
`define DTEC_A_CK_HI 4
`define DTEC_A_CK_LO 2
`define DTEC_CN 1
`define DTEC_ST 0
`define DTEC_B_POL 7
`define DTEC_B_WIDE 6
`define DTEC_B_PWM 5
`define DTEC_B_CAP 4
`define DTEC_B_CK_HI 3
`define DTEC_B_CK_LO 2
`define DTEC_HI_PE 7
// ==========================================================
// Clock select codes.
`define DTEC_A_CK_EXT 3'h7
`define DTEC_B_CK_A 2'h3
`define DTEC_PRESCALE_W 12
`endif

/* File: core/dtec_pkg.sv */
// Types shared by the dual timer files.
package dtec_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} dtec_bus_t;
	typedef struct packed {
		logic extCount;
		logic captureTriggerA;
		logic captureTriggerB;
	} dtec_pins_t;
	typedef enum logic [1:0] {
		DTEC_M_TIMER,
		DTEC_M_CAPTURE,
		DTEC_M_PWM
	} dtec_mode_t;
endpackage

/* File: core/dtec_prescaler.sv */
// Free running prescaler producing one-cycle ticks at the counter source rates.
`timescale 1ns/10ps
`include "dtec_defines.svh"
module dtec_prescaler #(
	parameter int W = `DTEC_PRESCALE_W
) (
	input wire logic clk,
	input wire logic rst,
	output logic [W:0] tick
);
	logic [W-1:0] div_q;
	logic [W-1:0] div_d;
	assign div_d = div_q + 1'b1;
	always_ff @(posedge clk) begin
		if (rst) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end
	// ==========================================================
	// Tick k fires once every 2^k cycles.
	assign tick[0] = 1'b1;
	genvar k;
	generate
		for (k = 1; k <= W; k++) begin : gTap
			assign tick[k] = &div_q[k-1:0];
		end
	endgenerate
endmodule // dtec_prescaler

/* File: core/dtec_counter8.sv */
// One eight bit counter slice with clear and capture register.
`timescale 1ns/10ps
module dtec_counter8 (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic inc,
	input wire logic clear,
	input wire logic capture,
	input wire logic [7:0] capValue,
	output logic [7:0] count,
	output logic [7:0] captured
);
	logic [7:0] count_q;
	logic [7:0] cap_q;
	always_ff @(posedge clk) begin
		if (rst || start || clear) begin
			count_q <= 8'h00;
		end else if (inc) begin
			count_q <= count_q + 8'h01;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			cap_q <= 8'h00;
		end else if (capture) begin
			cap_q <= capValue;
		end
	end
	assign count = count_q;
	assign captured = cap_q;
endmodule // dtec_counter8

/* File: core/dtec_timer.sv */
// Dual eight bit timer, sixteen bit pair, capture, compare output and ten bit pulse width output.
//
// Behaviour
// - Two 8-bit counters run alone or joined as one 16-bit counter.
// - Counter A clocks from fx/2..fx/4096 taps or the external count pin.
// - Counter B clocks from fx, fx/2, fx/16 or A's clock, which can be the pin.
// - External pin selected: A increments on each rising pin edge.
// - Each 8-bit counter raises its own interrupt on compare match.
// - Wide mode: A low byte, B high byte, clear to zero, only A interrupt.
// - Capture mode copies count to capture register on trigger input.
// - Capture mode still interrupts on match and clears the counter.
// - Capture mode reads of the shared address return the capture register.
// - Wide capture captures and clears the full 16-bit pair.
// - PWM mode drives a 10-bit waveform on B pin when B output enabled.
// - Period and duty are 10 bits: high bits above period and duty bytes.
// - Duty equal period gives constant sense level; duty zero gives its inverse.
// - Duty match clears output with sense zero, sets it with sense one.
// - Compare output toggles on every match, giving a square wave.
// - Compare output appears on B pin only when B output enabled.
// - A drives its compare result; B drives compare or PWM waveform.
`timescale 1ns/10ps
`include "dtec_defines.svh"
module dtec_timer
	import dtec_pkg::*;
#(
	parameter int PRESCALE_W = `DTEC_PRESCALE_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire dtec_pkg::dtec_bus_t bus,
	input wire dtec_pkg::dtec_pins_t pins,
	output logic [7:0] rdData_q,
	output logic irqA_q,
	output logic irqB_q,
	output logic outA_q,
	output logic outAEn_q,
	output logic waveformOutputPin_q,
	output logic waveformOutputEn_q,
	output logic extCountInput_q
);
	import dtec_pkg::*;
	// ==========================================================
	// Register file.
	logic [7:0] ctrlA_q;
	logic [7:0] ctrlB_q;
	logic [7:0] cmpA_q;
	logic [7:0] cmpB_q;
	logic [7:0] periodLow_q;
	logic [7:0] dutyLow_q;
	logic [7:0] hiBits_q;
	logic [7:0] countA;
	logic [7:0] countB;
	logic [7:0] capA;
	logic [7:0] capB;
	logic wrACtrl;
	logic wrAData;
	logic wrBCtrl;
	logic wrBCmp;
	logic wrBData;
	logic wrHi;
	function automatic logic hit(input dtec_bus_t b, input logic [7:0] off);
		hit = b.wr && (b.addr == off);
	endfunction
	assign wrACtrl = hit(bus, `DTEC_OFF_A_CTRL);
	assign wrAData = hit(bus, `DTEC_OFF_A_DATA);
	assign wrBCtrl = hit(bus, `DTEC_OFF_B_CTRL);
	assign wrBCmp = hit(bus, `DTEC_OFF_B_CMP);
	assign wrBData = hit(bus, `DTEC_OFF_B_DATA);
	assign wrHi = hit(bus, `DTEC_OFF_PWM_HI);
	logic pwmMode;
	logic wide;
	logic capModeA;
	logic capModeB;
	assign wide = ctrlB_q[`DTEC_B_WIDE];
	assign pwmMode = ctrlB_q[`DTEC_B_PWM] && !wide;
	assign capModeA = ctrlA_q[`DTEC_A_CAP];
	assign capModeB = ctrlB_q[`DTEC_B_CAP];
	dtec_mode_t modeB;
	assign modeB = pwmMode ? DTEC_M_PWM : (capModeB ? DTEC_M_CAPTURE : DTEC_M_TIMER);
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrlA_q <= `DTEC_RST_CTRL;
			ctrlB_q <= `DTEC_RST_CTRL;
			cmpA_q <= `DTEC_RST_CMP;
			cmpB_q <= `DTEC_RST_CMP;
			periodLow_q <= `DTEC_RST_CMP;
			dutyLow_q <= `DTEC_RST_DUTY;
			hiBits_q <= `DTEC_RST_HI;
		end else begin
			if (wrACtrl) ctrlA_q <= bus.wdata;
			if (wrAData) cmpA_q <= bus.wdata;
			if (wrBCtrl) ctrlB_q <= bus.wdata;
			if (wrBCmp && pwmMode) periodLow_q <= bus.wdata;
			if (wrBCmp && !pwmMode) cmpB_q <= bus.wdata;
			if (wrBData && pwmMode) dutyLow_q <= bus.wdata;
			if (wrHi) hiBits_q <= bus.wdata;
		end
	end
	// ==========================================================
	// Clock source selection.
	logic [PRESCALE_W:0] tick;
	dtec_prescaler #(.W(PRESCALE_W)) uPrescaler (
		.clk(clk),
		.rst(rst),
		.tick(tick)
	);
	logic extPrev_q;
	logic extRise;
	logic [2:0] ckA;
	logic [1:0] ckB;
	logic tickA;
	logic tickB;
	assign ckA = ctrlA_q[`DTEC_A_CK_HI:`DTEC_A_CK_LO];
	assign ckB = ctrlB_q[`DTEC_B_CK_HI:`DTEC_B_CK_LO];
	assign extRise = pins.extCount && !extPrev_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			extPrev_q <= 1'b0;
		end else begin
			extPrev_q <= pins.extCount;
		end
	end
	always_comb begin
		case (ckA)
			3'h0: tickA = tick[1];
			3'h1: tickA = tick[2];
			3'h2: tickA = tick[4];
			3'h3: tickA = tick[6];
			3'h4: tickA = tick[8];
			3'h5: tickA = tick[10];
			3'h6: tickA = tick[12];
			default: tickA = extRise;
		endcase
	end
	always_comb begin
		case (ckB)
			2'h0: tickB = tick[0];
			2'h1: tickB = tick[1];
			2'h2: tickB = tick[4];
			default: tickB = tickA;
		endcase
	end
	// ==========================================================
	// Counting, match and capture.
	logic runA;
	logic runB;
	logic incA;
	logic incB;
	logic matchA;
	logic matchB;
	logic matchW;
	logic clrA;
	logic clrB;
	logic capStrA;
	logic capStrB;
	logic startA;
	logic startB;
	logic pwmEnd;
	logic [9:0] pwmCnt_q;
	assign runA = ctrlA_q[`DTEC_A_EN] && ctrlA_q[`DTEC_ST] && ctrlA_q[`DTEC_CN];
	assign runB = ctrlB_q[`DTEC_ST] && ctrlB_q[`DTEC_CN];
	assign startA = wrACtrl && bus.wdata[`DTEC_ST] && !ctrlA_q[`DTEC_ST];
	assign startB = wrBCtrl && bus.wdata[`DTEC_ST] && !ctrlB_q[`DTEC_ST];
	assign matchA = runA && tickA && (countA == cmpA_q);
	assign matchB = runB && tickB && (countB == cmpB_q) && !pwmMode;
	assign matchW = runA && tickA && ({countB, countA} == {cmpB_q, cmpA_q});
	assign incA = runA && tickA;
	// Wide pair: B carries when A wraps past 0xFF.
	assign incB = wide ? (incA && countA == 8'hFF) : (runB && tickB && !pwmMode);
	assign clrA = wide ? matchW : matchA;
	assign clrB = wide ? matchW : (matchB || pwmEnd);
	assign capStrA = (wide ? capModeB : capModeA) && pins.captureTriggerA;
	assign capStrB = wide ? capStrA : (capModeB && pins.captureTriggerB);
	logic [7:0] capA_unused;
	dtec_counter8 uCountA (
		.clk(clk),
		.rst(rst),
		.start(startA),
		.inc(incA),
		.clear(clrA),
		.capture(capStrA),
		.capValue(countA),
		.count(countA),
		.captured(capA_unused)
	);
	// ==========================================================
	// Pulse width generator on counter B source.
	logic [9:0] period;
	logic [9:0] duty;
	logic pwmLevel_q;
	logic duty_level_sense;
	logic pwmTick;
	assign duty_level_sense = ctrlB_q[`DTEC_B_POL];
	assign period = {hiBits_q[3:2], periodLow_q};
	assign duty = {hiBits_q[1:0], dutyLow_q};
	assign pwmTick = pwmMode && runB && tickB;
	assign pwmEnd = pwmTick && (pwmCnt_q >= period - 10'd1);
	always_ff @(posedge clk) begin
		if (rst || startB || !pwmMode) begin
			pwmCnt_q <= 10'd0;
		end else if (pwmEnd) begin
			pwmCnt_q <= 10'd0;
		end else if (pwmTick) begin
			pwmCnt_q <= pwmCnt_q + 10'd1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			pwmLevel_q <= 1'b0;
		end else if (duty == period) begin
			pwmLevel_q <= duty_level_sense;
		end else if (duty == 10'd0) begin
			pwmLevel_q <= !duty_level_sense;
		end else if (pwmTick && pwmCnt_q == duty - 10'd1) begin
			pwmLevel_q <= duty_level_sense;
		end else if (pwmEnd) begin
			pwmLevel_q <= !duty_level_sense;
		end
	end
	// ==========================================================
	// Compare toggles and pins.
	logic togA_q;
	logic togB_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			togA_q <= 1'b0;
			togB_q <= 1'b0;
		end else begin
			if (clrA) togA_q <= !togA_q;
			if (wide ? matchW : matchB) togB_q <= !togB_q;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			outA_q <= 1'b0;
			outAEn_q <= 1'b0;
			waveformOutputPin_q <= 1'b0;
			waveformOutputEn_q <= 1'b0;
			extCountInput_q <= 1'b0;
			irqA_q <= 1'b0;
			irqB_q <= 1'b0;
		end else begin
			outA_q <= togA_q;
			outAEn_q <= ctrlA_q[`DTEC_A_PE] && (ckA != `DTEC_A_CK_EXT);
			waveformOutputPin_q <= (modeB == DTEC_M_PWM) ? pwmLevel_q : togB_q;
			waveformOutputEn_q <= hiBits_q[`DTEC_HI_PE];
			extCountInput_q <= (ckA == `DTEC_A_CK_EXT);
			irqA_q <= wide ? matchW : matchA;
			irqB_q <= wide ? 1'b0 : matchB;
		end
	end
	// ==========================================================
	// Read path; shared addresses return capture data in capture mode.
	logic [7:0] capAReg_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			capAReg_q <= 8'h00;
		end else if (capStrA) begin
			capAReg_q <= countA;
		end
	end
	dtec_counter8 uCountB (
		.clk(clk),
		.rst(rst),
		.start(startB),
		.inc(incB),
		.clear(clrB),
		.capture(capStrB),
		.capValue(countB),
		.count(countB),
		.captured(capB)
	);
	logic [7:0] rdNext;
	logic capRdA;
	logic capRdB;
	assign capRdA = wide ? capModeB : capModeA;
	assign capRdB = capModeB;
	assign rdNext = !bus.rd ? 8'h00 :
		(bus.addr == `DTEC_OFF_A_CTRL) ? ctrlA_q :
		(bus.addr == `DTEC_OFF_A_DATA) ? (capRdA ? capAReg_q : countA) :
		(bus.addr == `DTEC_OFF_B_CTRL) ? ctrlB_q :
		(bus.addr == `DTEC_OFF_B_DATA) ? (pwmMode ? dutyLow_q : (capRdB ? capB : countB)) :
		(bus.addr == `DTEC_OFF_PWM_HI) ? {1'b0, 3'h0, hiBits_q[3:0]} : 8'h00;
	always_ff @(posedge clk) begin
		if (rst) begin
			rdData_q <= 8'h00;
		end else begin
			rdData_q <= rdNext;
		end
	end
endmodule // dtec_timer

/* File: test/dtec_timer_chk.sv */
// Checker of the dual timer port behaviour.
`timescale 1ns/10ps
module dtec_timer_chk
	import dtec_pkg::*;
#(
	parameter int PRESCALE_W = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire dtec_pkg::dtec_bus_t bus,
	input wire logic [7:0] rdData_q,
	input wire logic irqA_q,
	input wire logic irqB_q,
	input wire logic outAEn_q,
	input wire logic waveformOutputEn_q,
	input wire logic extCountInput_q
);
	// ==========
	// Shadow of the control fields.
	logic [7:0] aCtrl_q;
	logic wide_q;
	logic hiPe_q;
	wire wrA = bus.wr && bus.addr == 8'hB2;
	wire wrB = bus.wr && bus.addr == 8'hB4;
	wire wrH = bus.wr && bus.addr == 8'hB7;
	wire aExt = aCtrl_q[4:2] == 3'h7;
	wire aPe = aCtrl_q[6] && !aExt;
	always_ff @(posedge clk) begin
		if (rst) begin
			aCtrl_q <= 8'h00;
			wide_q <= 1'b0;
			hiPe_q <= 1'b0;
		end else begin
			if (wrA) aCtrl_q <= bus.wdata;
			if (wrB) wide_q <= bus.wdata[6];
			if (wrH) hiPe_q <= bus.wdata[7];
		end
	end
	// ==========
	// Assertions.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_rd_bad;
		bus.rd && (bus.addr < 8'hB2 || bus.addr > 8'hB7);
	endsequence
	a_read_unmapped: assert property (s_rd_bad |=> rdData_q == 8'h00)
		else $error("unmapped read gave data");
	a_read_idle: assert property (!bus.rd |=> rdData_q == 8'h00)
		else $error("read data outside read cycle");
	a_irqa_pulse: assert property (irqA_q |=> !irqA_q)
		else $error("irq a longer than one cycle");
	a_irqb_pulse: assert property (irqB_q |=> !irqB_q)
		else $error("irq b longer than one cycle");
	a_wide_no_irqb: assert property (wide_q [*3] |-> !irqB_q)
		else $error("irq b in wide mode");
	a_ext_input: assert property (aExt [*3] |-> extCountInput_q)
		else $error("count pin not input");
	a_ext_released: assert property (!aExt [*3] |-> !extCountInput_q)
		else $error("count pin input when unused");
	a_outa_off: assert property (!aPe [*3] |-> !outAEn_q)
		else $error("out a enabled while off");
	a_pin_off: assert property (!hiPe_q [*3] |-> !waveformOutputEn_q)
		else $error("pin b enabled while off");
endmodule // dtec_timer_chk
bind dtec_timer dtec_timer_chk #(.PRESCALE_W(PRESCALE_W)) i_chk (.clk(clk), .rst(rst), .bus(bus),
	.rdData_q(rdData_q), .irqA_q(irqA_q), .irqB_q(irqB_q), .outAEn_q(outAEn_q),
	.waveformOutputEn_q(waveformOutputEn_q), .extCountInput_q(extCountInput_q));

/* File: test/dtec_pin_model.sv */
// Model of the external count and capture trigger pins.
`timescale 1ns/10ps
module dtec_pin_model
	import dtec_pkg::*;
(
	input wire logic clk,
	output dtec_pkg::dtec_pins_t pins
);
	// ==========
	// Pin drivers, idle low.
	initial begin
		pins = '0;
	end
	task automatic edges(input int n);
		repeat (n) begin
			@(posedge clk);
			pins.extCount <= 1'b1;
			repeat (2) @(posedge clk);
			pins.extCount <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic trig_a();
		@(posedge clk);
		pins.captureTriggerA <= 1'b1;
		@(posedge clk);
		pins.captureTriggerA <= 1'b0;
	endtask
endmodule // dtec_pin_model

/* File: test/tb.sv */
// Self-checking bench of the dual timer.
`timescale 1ns/10ps
module tb;
	import dtec_pkg::*;
	// ==========
	// Signals and design.
	logic clk = 1'b0;
	logic rst = 1'b1;
	dtec_bus_t bus = '0;
	dtec_pins_t pins;
	logic [7:0] rdData_q;
	logic irqA_q, irqB_q, outA_q, outAEn_q, waveformOutputPin_q, waveformOutputEn_q, extCountInput_q;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	logic [15:0] expQ[$];
	logic rdSeen = 1'b0;
	always #2 clk = ~clk;
	dtec_timer i_dut (.clk(clk), .rst(rst), .bus(bus), .pins(pins), .rdData_q(rdData_q), .irqA_q(irqA_q),
		.irqB_q(irqB_q), .outA_q(outA_q), .outAEn_q(outAEn_q), .waveformOutputPin_q(waveformOutputPin_q),
		.waveformOutputEn_q(waveformOutputEn_q), .extCountInput_q(extCountInput_q));
	dtec_pin_model i_pins (.clk(clk), .pins(pins));
	// ==========
	// Tasks.
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		if (mismatches == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expQ.push_back({8'h00, e});
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
	endtask
	task automatic gap(input logic b, output int n);
		repeat (2) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while ((b ? irqB_q : irqA_q) !== 1'b1 && n < 4000);
		end
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			final_report();
		end
	end
	always @(negedge clk) begin
		if (rdSeen) begin
			check("read data", {8'h00, rdData_q}, expQ.pop_front());
		end
		rdSeen = bus.rd;
	end
	// ==========
	// Scenarios.
	initial begin
		int cmp;
		int n;
		int e;
		int div[3] = '{2, 4, 16};
		int divB[3] = '{1, 2, 16};
		logic [7:0] duty[3] = '{8'h00, 8'h03, 8'h08};
		void'($urandom(62870));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(8'hB2, 8'h00);
		rd(8'hB3, 8'h00);
		rd(8'hB6, 8'h00);
		rd(8'hB0, 8'h00);
		for (int c = 0; c < 3; c++) begin
			cmp = 4 + $urandom % 8;
			wr(8'hB2, 8'h00);
			wr(8'hB3, cmp[7:0]);
			wr(8'hB2, 8'hC3 | 8'(c << 2));
			gap(1'b0, n);
			check("period a", n[15:0], 16'(div[c] * (cmp + 1)));
		end
		check("out a enable", {15'h0, outAEn_q}, 16'h0001);
		wr(8'hB2, 8'h00);
		for (int c = 0; c < 3; c++) begin
			cmp = 4 + $urandom % 8;
			wr(8'hB4, 8'h00);
			wr(8'hB5, cmp[7:0]);
			wr(8'hB4, 8'h03 | 8'(c << 2));
			gap(1'b1, n);
			check("period b", n[15:0], 16'(divB[c] * (cmp + 1)));
		end
		wr(8'hB4, 8'h00);
		wr(8'hB3, 8'h04);
		wr(8'hB5, 8'h01);
		wr(8'hB4, 8'h4F);
		wr(8'hB2, 8'h83);
		gap(1'b0, n);
		check("period wide", n[15:0], 16'd522);
		repeat (2) @(negedge clk);
		e = outA_q;
		do @(negedge clk); while (irqA_q !== 1'b1);
		repeat (2) @(negedge clk);
		check("out a toggle", {15'h0, outA_q}, {15'h0, !e[0]});
		wr(8'hB2, 8'h00);
		wr(8'hB4, 8'h00);
		wr(8'hB3, 8'h20);
		wr(8'hB2, 8'hBF);
		i_pins.edges(3);
		i_pins.trig_a();
		i_pins.edges(2);
		rd(8'hB3, 8'h03);
		check("ext input", {15'h0, extCountInput_q}, 16'h0001);
		wr(8'hB2, 8'h00);
		for (int s = 0; s < 2; s++) begin
			for (int d = 0; d < 3; d++) begin
				wr(8'hB4, 8'h23 | 8'(s << 7));
				wr(8'hB7, 8'h80);
				wr(8'hB5, 8'h08);
				wr(8'hB6, duty[d]);
				repeat (32) @(posedge clk);
				n = 0;
				repeat (64) begin
					@(negedge clk);
					n += (waveformOutputPin_q === 1'b1);
				end
				e = (d == 2) ? 64 * s : (d == 0) ? 64 * (1 - s) : (s == 1) ? 8 * 5 : 8 * 3;
				check("pwm high", n[15:0], e[15:0]);
			end
		end
		check("pin b enable", {15'h0, waveformOutputEn_q}, 16'h0001);
		final_report();
	end
endmodule // tb
